// file: bench/cfb_bridge_properties.sv
// Concurrent checks on the bridge's ports
`timescale 1ns/1ps
`default_nettype none
module cfb_bridge_properties (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        hba_memory_mode,
  input wire logic        hba_soft_reset,
  input wire logic        hba_cm_req,
  input wire logic        hba_cm_write,
  input wire logic        hba_wide,
  input wire logic [10:0] hba_addr,
  input wire logic [15:0] hba_rdata,
  input wire logic        host_ready_busy_n,
  input wire logic        flash_busy_in_n,
  input wire logic        flash_byte_mode_sel_n,
  input wire logic        flash_byte_select,
  input wire logic [9:0]  flash_word_address,
  input wire logic        flash_reset_out_n,
  input wire logic        flash_output_enable_n,
  input wire logic        flash_chip_enable_n,
  input wire logic        flash_write_enable_n,
  input wire logic [15:0] flash_data_bus_in,
  input wire logic        flash_data_bus_oe,
  input wire logic        dsp_rd_n,
  input wire logic        dsp_data_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_flash_idle: assert property (!hba_cm_req |=> flash_chip_enable_n && flash_write_enable_n
    && flash_output_enable_n) else $error("flash strobe active outside access");
  chk_read_strobe: assert property (hba_cm_req && !hba_cm_write |=> !flash_chip_enable_n
    && !flash_output_enable_n && flash_write_enable_n) else $error("read strobes wrong");
  chk_write_strobe: assert property (hba_cm_req && hba_cm_write |=> !flash_chip_enable_n
    && !flash_write_enable_n && flash_data_bus_oe) else $error("write strobes wrong");
  chk_word_addr: assert property (hba_cm_req |=> flash_word_address == $past(hba_addr[10:1]))
    else $error("word address wrong");
  chk_byte_mode: assert property (hba_cm_req |=> flash_byte_mode_sel_n == $past(hba_wide)
    && flash_byte_select == ($past(hba_addr[0]) && !$past(hba_wide))) else $error("byte mode wrong");
  chk_read_data: assert property (hba_cm_req && !hba_cm_write && hba_wide && !flash_output_enable_n
    |=> hba_rdata == $past(flash_data_bus_in)) else $error("read data wrong");
  chk_soft_reset: assert property (hba_soft_reset && hba_memory_mode
    |=> !flash_reset_out_n && !host_ready_busy_n) else $error("soft reset not seen");
  chk_busy_follow: assert property ((hba_memory_mode && !hba_soft_reset && !flash_busy_in_n)[*8]
    |-> !host_ready_busy_n) else $error("busy not passed on");
  chk_dsp_release: assert property (dsp_rd_n[*8] |-> !dsp_data_oe)
    else $error("dsp bus driven outside read");
endmodule : cfb_bridge_properties
bind cfb_bridge cfb_bridge_properties cfb_bridge_properties_i (.clk_sys, .reset, .hba_memory_mode,
  .hba_soft_reset, .hba_cm_req, .hba_cm_write, .hba_wide, .hba_addr, .hba_rdata, .host_ready_busy_n,
  .flash_busy_in_n, .flash_byte_mode_sel_n, .flash_byte_select, .flash_word_address, .flash_reset_out_n,
  .flash_output_enable_n, .flash_chip_enable_n, .flash_write_enable_n, .flash_data_bus_in,
  .flash_data_bus_oe, .dsp_rd_n, .dsp_data_oe);
`default_nettype wire

// file: bench/cfb_flash_model.sv
// Behavioural flash partner on the bridge's Common Memory side
`timescale 1ns/1ps
`default_nettype none
module cfb_flash_model (
  input  wire logic        clk_sys,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        byte_n,
  input  wire logic        bsel,
  input  wire logic [9:0]  waddr,
  input  wire logic [15:0] wdata,
  input  wire logic        busy_req,
  input  wire logic        wait_req,
  output logic      [15:0] rdata,
  output logic             busy_n,
  output logic             wait_n
);
  // ------
  // Storage and bus
  // ------
  logic [15:0] mem [16];
  logic [15:0] word;
  initial rdata = 16'h5a5a;
  assign word   = mem[waddr[3:0]];
  assign busy_n = ~busy_req;
  assign wait_n = ~wait_req;
  always @(posedge clk_sys) begin
    if (!ce_n && !we_n) begin
      mem[waddr[3:0]] <= wdata;
    end
    if (!ce_n && !oe_n) begin
      rdata <= byte_n ? word : {8'h00, bsel ? word[15:8] : word[7:0]};
    end else begin
      // A released bus inverts every cycle, so it shows the last word only on alternate cycles
      rdata <= ~rdata;
    end
  end
endmodule : cfb_flash_model
`default_nettype wire

// file: bench/tb.sv
// Self-checking testbench for the card-side bridge
`timescale 1ns/1ps
`default_nettype none
`include "cfb_regs.svh"
module tb;
  logic        clk_sys, reset, hba_memory_mode, hba_soft_reset, hba_cm_req, hba_cm_write, hba_wide;
  logic        hba_io_req, hba_io_rd, hba_io_wr, host_ready_busy_n, host_wait_n, busy_req, wait_req;
  logic        flash_busy_in_n, flash_wait_in_n, flash_byte_mode_sel_n, flash_byte_select, flash_reset_out_n;
  logic        flash_output_enable_n, flash_chip_enable_n, flash_write_enable_n, flash_data_bus_oe;
  logic        dsp_ioms_n, dsp_rd_n, dsp_wr_n, dsp_data_oe, dsp_fifo_ready;
  logic [1:0]  hba_io_addr;
  logic [7:0]  hba_io_wdata, hba_io_rdata, dsp_data_in, dsp_data_out, dsp_drv, q;
  logic [9:0]  flash_word_address;
  logic [10:0] hba_addr, dsp_addr;
  logic [15:0] hba_wdata, hba_rdata, flash_data_bus_in, flash_data_bus_out, fl_rdata;
  int          errors, n_tests;
  // Both shared buses resolve from whoever enables
  assign flash_data_bus_in = flash_data_bus_oe ? flash_data_bus_out : fl_rdata;
  assign dsp_data_in = dsp_data_oe ? dsp_data_out : dsp_drv;
  cfb_bridge cfb_bridge_i (.clk_sys, .reset, .hba_memory_mode, .hba_soft_reset, .hba_cm_req, .hba_cm_write,
    .hba_wide, .hba_addr, .hba_wdata, .hba_rdata, .hba_io_req, .hba_io_rd, .hba_io_wr, .hba_io_addr,
    .hba_io_wdata, .hba_io_rdata, .host_ready_busy_n, .host_wait_n, .flash_busy_in_n, .flash_wait_in_n,
    .flash_byte_mode_sel_n, .flash_byte_select, .flash_word_address, .flash_reset_out_n,
    .flash_output_enable_n, .flash_chip_enable_n, .flash_write_enable_n, .flash_data_bus_in,
    .flash_data_bus_out, .flash_data_bus_oe, .dsp_addr, .dsp_ioms_n, .dsp_rd_n, .dsp_wr_n, .dsp_data_in,
    .dsp_data_out, .dsp_data_oe, .dsp_fifo_ready);
  cfb_flash_model cfb_flash_model_i (.clk_sys, .ce_n(flash_chip_enable_n), .oe_n(flash_output_enable_n),
    .we_n(flash_write_enable_n), .byte_n(flash_byte_mode_sel_n), .bsel(flash_byte_select),
    .waddr(flash_word_address), .wdata(flash_data_bus_out), .busy_req, .wait_req, .rdata(fl_rdata),
    .busy_n(flash_busy_in_n), .wait_n(flash_wait_in_n));
  // ------
  // Shared tasks
  // ------
  task automatic results();
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_on(ref logic s, input logic v);
    #1;
    for (int k = 0; k < 60 && s !== v; k++) begin
      @(posedge clk_sys);
      #1;
    end
    chk(16'(s), 16'(v));
    if (s !== v) begin
      results();
    end
  endtask : wait_on
  task automatic cm(input logic wr, input logic wide, input logic [10:0] a, input logic [15:0] d, input int n);
    @(posedge clk_sys);
    hba_cm_req <= 1'b1;
    hba_cm_write <= wr;
    hba_wide <= wide;
    hba_addr <= a;
    hba_wdata <= d;
    repeat (n) @(posedge clk_sys);
    hba_cm_req <= 1'b0;
    #1;
  endtask : cm
  task automatic io(input logic wr, input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    hba_io_rd <= ~wr;
    hba_io_wr <= wr;
    hba_io_addr <= a;
    hba_io_wdata <= d;
    @(posedge clk_sys);
    hba_io_rd <= 1'b0;
    hba_io_wr <= 1'b0;
    #1 q = hba_io_rdata;
  endtask : io
  task automatic dsp(input logic rd, input logic [10:0] a, input logic [7:0] d, input logic sel_n);
    @(posedge clk_sys);
    dsp_ioms_n <= sel_n;
    dsp_addr <= a;
    dsp_drv <= d;
    repeat (2) @(posedge clk_sys);
    if (rd) dsp_rd_n <= 1'b0; else dsp_wr_n <= 1'b0;
    repeat (7) @(posedge clk_sys);
    #1 q = dsp_data_in;
    @(posedge clk_sys);
    dsp_rd_n <= 1'b1;
    dsp_wr_n <= 1'b1;
    dsp_drv <= ~d;
    repeat (6) @(posedge clk_sys);
    dsp_ioms_n <= 1'b1;
  endtask : dsp
  // ------
  // Scenarios
  // ------
  task automatic t_flash();
    cm(1'b1, 1'b1, 11'h00a, 16'hbeef, 3);
    cm(1'b0, 1'b1, 11'h00a, 16'h0000, 5);
    chk(hba_rdata, 16'hbeef);
    chk({6'h00, flash_word_address}, 16'h0005);
    for (int b = 0; b < 2; b++) begin
      cm(1'b0, 1'b0, {10'h005, b[0]}, 16'h0000, 3);
      chk({14'h0, flash_byte_mode_sel_n, flash_byte_select}, {15'h0, b[0]});
      chk({8'h00, b[0] ? hba_rdata[15:8] : hba_rdata[7:0]}, b[0] ? 16'h00be : 16'h00ef);
    end
    repeat (2) @(posedge clk_sys);
    chk({13'h0, flash_chip_enable_n, flash_output_enable_n, flash_write_enable_n}, 16'h0007);
  endtask : t_flash
  task automatic t_busy_wait();
    busy_req <= 1'b1;
    wait_on(host_ready_busy_n, 1'b0);
    repeat (4) @(posedge clk_sys);
    busy_req <= 1'b0;
    hba_soft_reset <= 1'b1;
    wait_on(flash_reset_out_n, 1'b0);
    chk(16'(host_ready_busy_n), 16'h0000);
    @(posedge clk_sys);
    hba_soft_reset <= 1'b0;
    wait_on(host_ready_busy_n, 1'b1);
    @(posedge clk_sys);
    wait_req <= 1'b1;
    hba_cm_req <= 1'b1;
    wait_on(host_wait_n, 1'b0);
    @(posedge clk_sys);
    hba_cm_req <= 1'b0;
    wait_req <= 1'b0;
    wait_on(host_wait_n, 1'b1);
    @(posedge clk_sys);
    hba_io_req <= 1'b1;
    dsp_ioms_n <= 1'b0;
    wait_on(host_wait_n, 1'b0);
    @(posedge clk_sys);
    dsp_ioms_n <= 1'b1;
    wait_on(host_wait_n, 1'b1);
    @(posedge clk_sys);
    hba_io_req <= 1'b0;
  endtask : t_busy_wait
  task automatic t_io();
    hba_memory_mode <= 1'b0;
    dsp(1'b0, 11'h7fc, 8'h3c, 1'b0);
    wait_on(host_ready_busy_n, 1'b0);
    io(1'b0, `CFB_REG_ADDR, 8'h00);
    chk(16'(q), 16'h003c);
    wait_on(host_ready_busy_n, 1'b1);
    dsp(1'b0, 11'h000, 8'h55, 1'b1);
    io(1'b0, `CFB_REG_STATUS, 8'h00);
    chk(16'(q[2]), 16'h0000);
    io(1'b1, `CFB_REG_ADDR, 8'ha6);
    dsp(1'b1, 11'h400, 8'h00, 1'b0);
    chk(16'(q), 16'h00a6);
  endtask : t_io
  task automatic t_fifo();
    for (int i = 0; i < 5; i++) begin
      dsp(1'b0, 11'h001, 8'h10 + 8'(i), 1'b0);
    end
    chk(16'(dsp_fifo_ready), 16'h0000);
    io(1'b0, `CFB_REG_STATUS, 8'h00);
    chk(16'(q[1:0]), 16'h0002);
    for (int i = 0; i < 5; i++) begin
      io(1'b0, `CFB_REG_DATA, 8'h00);
      chk(16'(q), 16'h0010 + 16'(i));
      repeat (6) @(posedge clk_sys);
    end
    wait_on(host_ready_busy_n, 1'b1);
  endtask : t_fifo
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    {errors, n_tests} = '0;
    {hba_soft_reset, hba_cm_req, hba_cm_write, hba_wide, hba_io_req, hba_io_rd, hba_io_wr} = '0;
    {hba_addr, hba_wdata, hba_io_addr, hba_io_wdata, dsp_addr, dsp_drv, busy_req, wait_req} = '0;
    {reset, hba_memory_mode, dsp_ioms_n, dsp_rd_n, dsp_wr_n} = '1;
    repeat (10) @(posedge clk_sys);
    chk({14'h0, host_ready_busy_n, flash_reset_out_n}, 16'h0000);
    reset <= 1'b0;
    t_flash();
    t_busy_wait();
    t_io();
    t_fifo();
    results();
  end
endmodule : tb
`default_nettype wire

// file: design/cfb_bridge.sv
// Card-side bridge: host adapter to Common Memory flash and DSP I/O Space
// Notes on behaviour
// - Flash busy input, active low level, feeds host ready/busy as busy in Memory Mode
// - Flash wait input is active low; tie high when memory lacks wait
// - Byte-mode select low for 8-bit, high for 16-bit, as host requested
// - In 8-bit mode byte select high picks high byte, low picks low
// - In 16-bit mode byte select ignored; word address bit one is LSB
// - Flash high byte maps to odd host byte, low byte to even
// - Word address drives ten flash address lines, bits ten to one
// - Flash data travels over sixteen-bit two-way bus
// - Active-low reset output drives the flash
// - Active-low output enable drives flash during Common Memory reads
// - Active-low chip enable selects flash for Common Memory accesses
// - Active-low write enable strobes data into flash
// - Eleven-bit DSP address accepted; only two low bits decoded
// - DSP strobes ignored while DSP I/O select is high
// - Host I/O cycle extended while DSP I/O select is low
// - DSP read strobe makes device drive selected register on DSP bus
// - DSP write strobe captures DSP data into the address register or the data FIFO, as selected; status writes are dropped
// - Eight-bit DSP data bus driven by device only during DSP reads
// - Memory Mode ready/busy low in reset, else follows flash busy
// - During Common Memory access host wait follows flash wait input
// - I/O Mode request low on new DSP address or data, high after read
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// FIFO from DSP data writes to host reads
// ----------------------------------------------------------------------
module cfb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [CW-1:0]               count;
  } cfb_fifo_state_type;

  cfb_fifo_state_type st_ff;
  cfb_fifo_state_type nxt_st;
  logic               push;
  logic               pop;

  assign in_ready  = (st_ff.count != CW'(DEPTH));
  assign out_valid = (st_ff.count != '0);
  assign out_data  = st_ff.mem[st_ff.rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wr_ptr] = in_data;
      nxt_st.wr_ptr = (st_ff.wr_ptr == AW'(DEPTH - 1)) ? '0 : st_ff.wr_ptr + 1'b1;
    end
    if (pop) begin
      nxt_st.rd_ptr = (st_ff.rd_ptr == AW'(DEPTH - 1)) ? '0 : st_ff.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      nxt_st.count = st_ff.count + 1'b1;
    end else if (pop && !push) begin
      nxt_st.count = st_ff.count - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : cfb_fifo

// ----------------------------------------------------------------------
// Bridge top
// ----------------------------------------------------------------------
module cfb_bridge import cfb_pkg::*; #(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        hba_memory_mode,
  input  wire logic        hba_soft_reset,
  input  wire logic        hba_cm_req,
  input  wire logic        hba_cm_write,
  input  wire logic        hba_wide,
  input  wire logic [10:0] hba_addr,
  input  wire logic [15:0] hba_wdata,
  output logic      [15:0] hba_rdata,
  input  wire logic        hba_io_req,
  input  wire logic        hba_io_rd,
  input  wire logic        hba_io_wr,
  input  wire logic [1:0]  hba_io_addr,
  input  wire logic [7:0]  hba_io_wdata,
  output logic      [7:0]  hba_io_rdata,
  output logic             host_ready_busy_n,
  output logic             host_wait_n,
  input  wire logic        flash_busy_in_n,
  input  wire logic        flash_wait_in_n,
  output logic             flash_byte_mode_sel_n,
  output logic             flash_byte_select,
  output logic      [9:0]  flash_word_address,
  output logic             flash_reset_out_n,
  output logic             flash_output_enable_n,
  output logic             flash_chip_enable_n,
  output logic             flash_write_enable_n,
  input  wire logic [15:0] flash_data_bus_in,
  output logic      [15:0] flash_data_bus_out,
  output logic             flash_data_bus_oe,
  input  wire logic [10:0] dsp_addr,
  input  wire logic        dsp_ioms_n,
  input  wire logic        dsp_rd_n,
  input  wire logic        dsp_wr_n,
  input  wire logic [7:0]  dsp_data_in,
  output logic      [7:0]  dsp_data_out,
  output logic             dsp_data_oe,
  output logic             dsp_fifo_ready
);

  cfb_state_type          st_ff;
  cfb_state_type          nxt_st;
  logic [`CFB_SYNC_W-1:0] pins;
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  logic                   fifo_out_ready;
  logic [7:0]             fifo_out_data;
  logic                   dsp_sel;
  logic                   dsp_wr_evt;
  logic                   dsp_rd_evt;
  logic [1:0]             dsp_reg;
  logic [7:0]             dsp_wdata;
  logic [7:0]             status;
  logic                   host_rd_addr;
  logic [`CFB_SYNC_W-1:0] nxt_stable;

  // ----------------------------------------------------------------------
  // Pin capture
  // ----------------------------------------------------------------------
  // Upper DSP address bits carry no decode and are left unsampled
  assign pins = {dsp_data_in, dsp_addr[1:0], dsp_ioms_n, dsp_rd_n,
                 dsp_wr_n, flash_wait_in_n, flash_busy_in_n};

  // ----------------------------------------------------------------------
  // Data FIFO
  // ----------------------------------------------------------------------
  cfb_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) cfb_fifo_i (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_valid  (st_ff.pend_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (st_ff.pend_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  assign host_rd_addr   = hba_io_rd & (hba_io_addr == `CFB_REG_ADDR);
  assign fifo_out_ready = hba_io_rd & (hba_io_addr == `CFB_REG_DATA);

  // A waiting DSP word holds off the next one until the FIFO takes it
  assign dsp_fifo_ready = ~st_ff.pend_valid;

  assign status = {3'h0, ~st_ff.stable[`CFB_SY_BUSY], st_ff.hdat_new,
                   st_ff.addr_new, ~fifo_in_ready, ~fifo_out_valid};

  // ----------------------------------------------------------------------
  // DSP strobe events, taken on the filtered levels
  // ----------------------------------------------------------------------
  assign nxt_stable = (st_ff.sync2 & st_ff.sync3) |
                      (st_ff.stable & (st_ff.sync2 ^ st_ff.sync3));
  always_comb begin
    dsp_sel    = ~nxt_stable[`CFB_SY_IOMS];
    dsp_reg    = nxt_stable[`CFB_SY_ADDR_LO +: 2];
    dsp_wdata  = nxt_stable[`CFB_SY_DATA_LO +: 8];
    dsp_wr_evt = dsp_sel & st_ff.stable[`CFB_SY_WR] &
                 ~nxt_stable[`CFB_SY_WR];
    dsp_rd_evt = dsp_sel & st_ff.stable[`CFB_SY_RD] &
                 ~nxt_stable[`CFB_SY_RD];
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;

    // A change counts once the second and third stages agree
    nxt_st.sync1  = pins;
    nxt_st.sync2  = st_ff.sync1;
    nxt_st.sync3  = st_ff.sync2;
    nxt_st.stable = nxt_stable;

    // Flash cycle follows the host request
    unique case (st_ff.cm_state)
      CM_IDLE: begin
        if (hba_cm_req) begin
          nxt_st.cm_state = CM_ACTIVE;
        end
      end
      CM_ACTIVE: begin
        if (!hba_cm_req) begin
          nxt_st.cm_state = CM_IDLE;
        end
      end
    endcase

    if (hba_cm_req) begin
      nxt_st.ce_n   = 1'b0;
      nxt_st.oe_n   = hba_cm_write;
      nxt_st.we_n   = ~hba_cm_write;
      nxt_st.fdoe   = hba_cm_write;
      nxt_st.byte_n = hba_wide;
      nxt_st.waddr  = hba_addr[10:1];
      nxt_st.bsel   = hba_wide ? 1'b0 : hba_addr[0];
      if (hba_wide) begin
        nxt_st.fdout = hba_wdata;
      end else begin
        nxt_st.fdout = {8'h00, hba_addr[0] ? hba_wdata[15:8] : hba_wdata[7:0]};
      end
    end else begin
      nxt_st.ce_n = 1'b1;
      nxt_st.oe_n = 1'b1;
      nxt_st.we_n = 1'b1;
      nxt_st.fdoe = 1'b0;
    end

    // Read data is taken from the bus while the output enable is low
    if (st_ff.cm_state == CM_ACTIVE && !st_ff.oe_n) begin
      if (!st_ff.byte_n) begin
        if (st_ff.bsel) begin
          nxt_st.hrdata = {flash_data_bus_in[7:0], st_ff.hrdata[7:0]};
        end else begin
          nxt_st.hrdata = {st_ff.hrdata[15:8], flash_data_bus_in[7:0]};
        end
      end else begin
        nxt_st.hrdata = flash_data_bus_in;
      end
    end

    nxt_st.frst_n = ~hba_soft_reset;

    // Host side of the I/O Space
    if (hba_io_wr) begin
      if (hba_io_addr == `CFB_REG_ADDR) begin
        nxt_st.host_addr = hba_io_wdata;
      end else if (hba_io_addr == `CFB_REG_DATA) begin
        nxt_st.host_data = hba_io_wdata;
      end
    end
    if (hba_io_rd) begin
      unique case (hba_io_addr)
        `CFB_REG_ADDR:   nxt_st.hio_rdata = st_ff.addr_to_host;
        `CFB_REG_DATA:   nxt_st.hio_rdata = fifo_out_data;
        `CFB_REG_STATUS: nxt_st.hio_rdata = status;
        default:         nxt_st.hio_rdata = `CFB_BYTE_RST;
      endcase
    end

    // DSP writes; flag sets win over host clears
    if (dsp_wr_evt && dsp_reg == `CFB_REG_ADDR) begin
      nxt_st.addr_to_host = dsp_wdata;
    end
    nxt_st.addr_new = (dsp_wr_evt && dsp_reg == `CFB_REG_ADDR) |
                      (st_ff.addr_new & ~host_rd_addr);
    nxt_st.pend_valid = (st_ff.pend_valid & ~fifo_in_ready) |
                        (dsp_wr_evt && dsp_reg == `CFB_REG_DATA);
    if (dsp_wr_evt && dsp_reg == `CFB_REG_DATA) begin
      nxt_st.pend_data = dsp_wdata;
    end
    nxt_st.hdat_new = (hba_io_wr && hba_io_addr == `CFB_REG_DATA) |
                      (st_ff.hdat_new & ~(dsp_rd_evt && dsp_reg == `CFB_REG_DATA));

    // DSP reads: bus driven only while select and read strobe are low
    nxt_st.ddoe = dsp_sel & ~nxt_st.stable[`CFB_SY_RD];
    if (dsp_rd_evt) begin
      unique case (dsp_reg)
        `CFB_REG_ADDR:   nxt_st.ddout = st_ff.host_addr;
        `CFB_REG_DATA:   nxt_st.ddout = st_ff.host_data;
        `CFB_REG_STATUS: nxt_st.ddout = status;
        default:         nxt_st.ddout = `CFB_BYTE_RST;
      endcase
    end

    // Ready/busy in memory mode, request in I/O mode
    if (hba_memory_mode) begin
      nxt_st.rdy_n = ~hba_soft_reset & st_ff.stable[`CFB_SY_BUSY];
    end else begin
      nxt_st.rdy_n = ~(st_ff.addr_new | fifo_out_valid);
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_ff           <= '0;
      st_ff.sync1     <= '1;
      st_ff.sync2     <= '1;
      st_ff.sync3     <= '1;
      st_ff.stable    <= '1;
      st_ff.cm_state  <= CM_IDLE;
      st_ff.ce_n      <= 1'b1;
      st_ff.oe_n      <= 1'b1;
      st_ff.we_n      <= 1'b1;
      st_ff.frst_n    <= 1'b0;
      st_ff.rdy_n     <= 1'b0;
      st_ff.hrdata    <= `CFB_WORD_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Wait from flash during memory access, from DSP select during I/O access
  always_comb begin
    if (st_ff.cm_state == CM_ACTIVE) begin
      host_wait_n = st_ff.stable[`CFB_SY_WAIT];
    end else if (hba_io_req) begin
      host_wait_n = st_ff.stable[`CFB_SY_IOMS];
    end else begin
      host_wait_n = 1'b1;
    end
  end

  assign hba_rdata             = st_ff.hrdata;
  assign hba_io_rdata          = st_ff.hio_rdata;
  assign host_ready_busy_n     = st_ff.rdy_n;
  assign flash_byte_mode_sel_n = st_ff.byte_n;
  assign flash_byte_select     = st_ff.bsel;
  assign flash_word_address    = st_ff.waddr;
  assign flash_reset_out_n     = st_ff.frst_n;
  assign flash_output_enable_n = st_ff.oe_n;
  assign flash_chip_enable_n   = st_ff.ce_n;
  assign flash_write_enable_n  = st_ff.we_n;
  assign flash_data_bus_out    = st_ff.fdout;
  assign flash_data_bus_oe     = st_ff.fdoe;
  assign dsp_data_out          = st_ff.ddout;
  assign dsp_data_oe           = st_ff.ddoe;

endmodule : cfb_bridge

`default_nettype wire

// file: design/cfb_pkg.sv
// Types shared by the bridge logic
`include "cfb_regs.svh"
package cfb_pkg;

  typedef enum logic [1:0] {
    CM_IDLE   = 2'b01,
    CM_ACTIVE = 2'b10
  } cfb_cm_state_type;

  typedef struct packed {
    logic [`CFB_SYNC_W-1:0] sync1;
    logic [`CFB_SYNC_W-1:0] sync2;
    logic [`CFB_SYNC_W-1:0] sync3;
    logic [`CFB_SYNC_W-1:0] stable;
    cfb_cm_state_type       cm_state;
    logic                   ce_n;
    logic                   oe_n;
    logic                   we_n;
    logic                   byte_n;
    logic                   bsel;
    logic [9:0]             waddr;
    logic [15:0]            fdout;
    logic                   fdoe;
    logic                   frst_n;
    logic [15:0]            hrdata;
    logic [7:0]             hio_rdata;
    logic                   rdy_n;
    logic [7:0]             addr_to_host;
    logic [7:0]             host_addr;
    logic [7:0]             host_data;
    logic                   addr_new;
    logic                   hdat_new;
    logic [7:0]             pend_data;
    logic                   pend_valid;
    logic [7:0]             ddout;
    logic                   ddoe;
  } cfb_state_type;

endpackage : cfb_pkg

// file: design/cfb_regs.svh
// Register indices, field positions, reset values and sync layout of the bridge
`ifndef CFB_REGS_SVH
`define CFB_REGS_SVH

// I/O Space register indices (two decoded address bits)
`define CFB_REG_ADDR    2'h0
`define CFB_REG_DATA    2'h1
`define CFB_REG_STATUS  2'h2

// Status register fields
`define CFB_ST_EMPTY    0
`define CFB_ST_FULL     1
`define CFB_ST_ADDR_NEW 2
`define CFB_ST_HDAT_NEW 3
`define CFB_ST_BUSY     4

// Reset values
`define CFB_BYTE_RST    8'h00
`define CFB_WORD_RST    16'h0000

// Synchroniser vector layout
`define CFB_SYNC_W      15
`define CFB_SY_BUSY     0
`define CFB_SY_WAIT     1
`define CFB_SY_WR       2
`define CFB_SY_RD       3
`define CFB_SY_IOMS     4
`define CFB_SY_ADDR_LO  5
`define CFB_SY_DATA_LO  7

`endif
